// ===== pkg/rx_bp_pkg.sv
// constants for the receive backplane configuration block
// assumes a 32-bit axi4-lite slave and a separate link clock domain
package rx_bp_pkg;
  localparam logic [3:0] ctrl_addr = 4'h0;
  localparam logic [3:0] stat_addr = 4'h4;
  localparam logic [3:0] data_addr = 4'h8;
  localparam int mode_lsb = 0;
  localparam int mux_bit = 2;
  localparam int inv_bit = 3;
  localparam int sync_out_bit = 4;
  localparam int clk_out_bit = 5;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [1:0] mode_base = 2'h0;
  localparam logic [1:0] mode_hs2 = 2'h1;
  localparam logic [1:0] mode_hs4 = 2'h2;
  localparam logic [1:0] mode_hs8 = 2'h3;
  localparam int frame_bits = 256;
  localparam int lanes = 4;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  localparam logic [3:0] ff_div_half = 4'h4;
endpackage : rx_bp_pkg

// ===== testbench/bp_partner.sv
// backplane partner: link clock, frame boundary, data sampler
// assumes the device moves data on the edge chosen by inv
`timescale 1ns/1ps
`default_nettype none
module bp_partner (
  input wire logic run,
  input wire logic inv,
  input wire logic rx_backplane_serial_out,
  output logic rx_backplane_clock,
  output logic rx_frame_boundary_in,
  output logic [7:0] sampled_q
);
  logic [7:0] bit_q;
  initial begin
    rx_backplane_clock = 1'h0;
    rx_frame_boundary_in = 1'h0;
    bit_q = 8'h00;
    sampled_q = 8'h00;
  end
  // clock stands still while run is low
  always begin
    #24;
    if (run) rx_backplane_clock = ~rx_backplane_clock;
  end
  // one-bit boundary pulse every 256 bit times
  always @(negedge rx_backplane_clock) begin
    bit_q <= bit_q + 8'h01;
    rx_frame_boundary_in <= (bit_q == 8'hFF);
  end
  // sample opposite the transition edge, data has settled
  always @(rx_backplane_clock) begin
    if (rx_backplane_clock == inv) begin
      sampled_q <= {sampled_q[6:0], rx_backplane_serial_out};
    end
  end
endmodule : bp_partner
`default_nettype wire

// ===== testbench/e1_receive_backplane_config_tb.sv
// bench for the receive backplane block: registers, edges, lanes
// assumes bp_partner supplies link clock and frame boundary
`timescale 1ns/1ps
`default_nettype none
module e1_receive_backplane_config_tb;
  typedef struct packed {
    logic [3:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [1:0] wr;
    logic [31:0] rd;
    logic [1:0] rr;
  } row_t;
  localparam logic [1:0] ok = rx_bp_pkg::resp_okay;
  localparam logic [1:0] er = rx_bp_pkg::resp_slverr;
  // rate codes, interleave, invert, boundary drive, strobe, unmapped
  localparam row_t rows [9] = '{
    '{4'h0, 32'h01, 4'hF, ok, 32'h01, ok},
    '{4'h0, 32'h02, 4'hF, ok, 32'h02, ok},
    '{4'h0, 32'h03, 4'hF, ok, 32'h03, ok},
    '{4'h0, 32'h04, 4'hF, ok, 32'h04, ok},
    '{4'h0, 32'h07, 4'hF, ok, 32'h07, ok},
    '{4'h0, 32'h08, 4'hF, ok, 32'h08, ok},
    '{4'h0, 32'h10, 4'hF, ok, 32'h10, ok},
    '{4'h0, 32'hFF, 4'h0, ok, 32'h10, ok},
    '{4'hC, 32'h01, 4'hF, er, 32'h00, er}
  };
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [3:0] line_bits = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_arvalid = 1'h0;
  // answers are taken at once, so both stay high
  logic s_axi_bready = 1'h1;
  logic s_axi_rready = 1'h1;
  logic run = 1'h1;
  logic inv_m = 1'h0;
  logic chg_clk = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, v, v0;
  logic rx_backplane_clock, rx_frame_boundary_in, rx_frame_boundary_out;
  logic rx_frame_boundary_oe, rx_backplane_serial_out;
  logic [7:0] sampled_q;
  int err_count = 0;
  int checks_done = 0;
  int fb_pulses = 0;
  int p0;
  always #12.5 clk_sys = ~clk_sys;
  rx_bp_config dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_bits,
    .rx_backplane_clock, .rx_frame_boundary_in, .rx_frame_boundary_out,
    .rx_frame_boundary_oe, .rx_backplane_serial_out);
  bp_partner link (.run, .inv(inv_m), .rx_backplane_serial_out,
    .rx_backplane_clock, .rx_frame_boundary_in, .sampled_q);
  // link clock level seen when the data line last moved
  always @(rx_backplane_serial_out) chg_clk = rx_backplane_clock;
  // driven frame boundary pulses, counted for the wrap check
  always @(posedge rx_frame_boundary_out) fb_pulses++;
  task automatic final_report();
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] resp);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      n++;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    if (n >= 50) begin
      err_count++;
      final_report();
    end
    resp = s_axi_bresp;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      n++;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    if (n >= 50) begin
      err_count++;
      final_report();
    end
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : axi_rd
  // lanes alternate 1/0 when interleaved, so xor with a rotation is FF
  task automatic link_case(input logic [7:0] c, input logic [3:0] lb,
                           input logic lvl);
    logic [7:0] s;
    axi_wr(4'h0, {24'h0, c}, 4'hF, r);
    inv_m <= c[3] && (c[2:0] == 3'h0);
    line_bits <= lb;
    repeat (80) @(posedge clk_sys);
    s = c[2] ? sampled_q ^ {sampled_q[0], sampled_q[7:1]} : sampled_q;
    cmp({24'h0, s}, 32'hFF);
    line_bits[0] <= ~lb[0];
    repeat (20) @(posedge clk_sys);
    cmp({31'h0, chg_clk}, {31'h0, lvl});
  endtask : link_case
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    axi_rd(4'h0, v, r);
    cmp(v, {24'h0, rx_bp_pkg::ctrl_reset});
    for (int i = 0; i < 9; i++) begin
      axi_wr(rows[i].a, rows[i].d, rows[i].s, r);
      cmp({30'h0, r}, {30'h0, rows[i].wr});
      axi_rd(rows[i].a, v, r);
      cmp(v, rows[i].rd);
      cmp({30'h0, r}, {30'h0, rows[i].rr});
    end
    link_case(8'h00, 4'h1, 1'h1);
    link_case(8'h08, 4'h1, 1'h0);
    link_case(8'h09, 4'h1, 1'h1);
    link_case(8'h0B, 4'h1, 1'h1);
    link_case(8'h0C, 4'h5, 1'h1);
    axi_rd(4'h8, v, r);
    cmp(v, 32'h4);
    axi_wr(4'h0, 32'h10, 4'hF, r);
    repeat (20) @(posedge clk_sys);
    cmp({31'h0, rx_frame_boundary_oe}, 32'h1);
    @(posedge rx_backplane_clock);
    p0 = fb_pulses;
    @(posedge clk_sys);
    axi_rd(4'h4, v0, r);
    repeat (512) @(posedge rx_backplane_clock);
    cmp(32'(fb_pulses - p0), 32'h2);
    @(posedge clk_sys);
    axi_rd(4'h4, v, r);
    cmp((v - v0) & 32'hFF, 32'h2);
    rst <= 1'h1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    axi_rd(4'h0, v, r);
    cmp(v, {24'h0, rx_bp_pkg::ctrl_reset});
    cmp({31'h0, rx_frame_boundary_oe}, 32'h0);
    axi_wr(4'h0, 32'h11, 4'hF, r);
    repeat (20) @(posedge clk_sys);
    cmp({31'h0, rx_frame_boundary_oe}, 32'h0);
    final_report();
  end
endmodule : e1_receive_backplane_config_tb
`default_nettype wire

// ===== verilog/rx_bp_config.sv
// receive backplane serialiser with its control register
// assumes axi4-lite master on clk_sys and backplane clock from the partner
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - data changes on rising clock edge when invert is 0, falling when 1
// - clock invert only applies in base rate mode
// - interleave enable merges four channel streams onto the one output
// - interleaved mode runs the backplane at 16.384 MHz
// - the two-bit rate field is read differently with interleave on
// - rate 00 is base rate; clock is always an input from the partner
// - in base rate the frame boundary may be input or driven output
module rx_bp_config (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] line_bits,
  input wire logic rx_backplane_clock,
  input wire logic rx_frame_boundary_in,
  output logic rx_frame_boundary_out,
  output logic rx_frame_boundary_oe,
  output logic rx_backplane_serial_out
);
  // register and bus state
  logic [7:0] ctrl_q, ctrl_d;
  logic [3:0] waddr_q, waddr_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [31:0] wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [3:0] bits_q, bits_d;
  logic [7:0] frame_cnt_s1_q, frame_cnt_s2_q;
  logic [3:0] lb_sys_s1_q;
  logic [7:0] frame_cnt_sys;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb begin
    ctrl_d = ctrl_q;
    waddr_d = waddr_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    bits_d = lb_sys_s1_q; // pin bits: second synchroniser flop
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = rx_bp_pkg::resp_okay;
      if (waddr_q == rx_bp_pkg::ctrl_addr) begin
        if (wstrb0_q) ctrl_d = wdata_q[7:0];
      end else begin
        bresp_d = rx_bp_pkg::resp_slverr;
      end
    end
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = rx_bp_pkg::resp_okay;
      case (s_axi_araddr)
        rx_bp_pkg::ctrl_addr: rdata_d = {24'h000000, ctrl_q};
        rx_bp_pkg::stat_addr: rdata_d = {24'h000000, frame_cnt_sys};
        rx_bp_pkg::data_addr: rdata_d = {28'h0000000, bits_q};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = rx_bp_pkg::resp_slverr;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= rx_bp_pkg::ctrl_reset;
      waddr_q <= 4'h0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
      bits_q <= 4'h0;
    end else begin
      ctrl_q <= ctrl_d;
      waddr_q <= waddr_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      bits_q <= bits_d;
    end
  end

  // link domain: control bits are quasi-static, two-flop synchronised
  // a new word is used only once two samples agree, so none is torn
  logic [7:0] ctrl_s1_q, ctrl_s2_q, ctrl_s3_q, ctrl_lk_q, ctrl_lk_d;
  logic rst_l1_q, rst_l2_q;
  assign ctrl_lk_d = (ctrl_s2_q == ctrl_s3_q) ? ctrl_s2_q : ctrl_lk_q;
  always_ff @(posedge rx_backplane_clock or posedge rst) begin
    if (rst) begin
      rst_l1_q <= 1'b1;
      rst_l2_q <= 1'b1;
      ctrl_s1_q <= rx_bp_pkg::ctrl_reset;
      ctrl_s2_q <= rx_bp_pkg::ctrl_reset;
      ctrl_s3_q <= rx_bp_pkg::ctrl_reset;
      ctrl_lk_q <= rx_bp_pkg::ctrl_reset;
    end else begin
      rst_l1_q <= 1'b0;
      rst_l2_q <= rst_l1_q;
      ctrl_s1_q <= ctrl_q;
      ctrl_s2_q <= ctrl_s1_q;
      ctrl_s3_q <= ctrl_s2_q;
      ctrl_lk_q <= ctrl_lk_d;
    end
  end

  logic lk_mux, lk_inv, lk_sync_out;
  logic [1:0] lk_mode;
  assign lk_mux = ctrl_lk_q[rx_bp_pkg::mux_bit];
  assign lk_mode = ctrl_lk_q[rx_bp_pkg::mode_lsb +: 2];
  // only base rate without interleave honours the edge select
  assign lk_inv = ctrl_lk_q[rx_bp_pkg::inv_bit] && !lk_mux &&
                  (lk_mode == rx_bp_pkg::mode_base);
  // frame boundary may be driven only in base rate
  assign lk_sync_out = ctrl_lk_q[rx_bp_pkg::sync_out_bit] && !lk_mux &&
                       (lk_mode == rx_bp_pkg::mode_base);

  // line bits sampled on the link clock through two flops
  logic [3:0] lb_s1_q, lb_s2_q;
  logic fb_s1_q, fb_s2_q, fb_s3_q;
  logic [7:0] bit_cnt_q, bit_cnt_d;
  logic [1:0] lane_q, lane_d;
  logic [7:0] frames_q, frames_d;
  logic ser_q, ser_d;
  logic sync_q, sync_d;
  logic [7:0] frame_gray_q;

  always_comb begin
    bit_cnt_d = bit_cnt_q;
    lane_d = lane_q;
    frames_d = frames_q;
    sync_d = 1'b0;
    // all high-speed rates shift one bit per partner clock
    if (lk_mux) begin
      lane_d = lane_q + 2'h1;
      ser_d = lb_s2_q[lane_q];
      if (lane_q == 2'(rx_bp_pkg::lanes - 1)) begin
        bit_cnt_d = bit_cnt_q + 8'h01;
      end
    end else begin
      lane_d = 2'h0;
      ser_d = lb_s2_q[0];
      bit_cnt_d = bit_cnt_q + 8'h01;
    end
    if (!lk_sync_out && fb_s2_q && !fb_s3_q) begin
      bit_cnt_d = 8'h00;
      lane_d = 2'h0;
    end
    if (bit_cnt_d == 8'h00 && bit_cnt_q != 8'h00) begin
      frames_d = frames_q + 8'h01;
      sync_d = lk_sync_out;
    end
  end

  always_ff @(posedge rx_backplane_clock or posedge rst) begin
    if (rst) begin
      lb_s1_q <= 4'h0;
      lb_s2_q <= 4'h0;
      fb_s1_q <= 1'b0;
      fb_s2_q <= 1'b0;
      fb_s3_q <= 1'b0;
      bit_cnt_q <= 8'h00;
      lane_q <= 2'h0;
      frames_q <= 8'h00;
      ser_q <= 1'b0;
      sync_q <= 1'b0;
      frame_gray_q <= 8'h00;
    end else begin
      lb_s1_q <= line_bits;
      lb_s2_q <= lb_s1_q;
      fb_s1_q <= rx_frame_boundary_in;
      fb_s2_q <= fb_s1_q;
      fb_s3_q <= fb_s2_q;
      if (rst_l2_q) begin
        bit_cnt_q <= 8'h00;
        lane_q <= 2'h0;
        frames_q <= 8'h00;
      end else begin
        bit_cnt_q <= bit_cnt_d;
        lane_q <= lane_d;
        frames_q <= frames_d;
      end
      ser_q <= ser_d;
      sync_q <= sync_d;
      frame_gray_q <= frames_d ^ (frames_d >> 1);
    end
  end

  // falling-edge copy lets the output change half a cycle later
  logic ser_neg_q, sync_neg_q;
  always_ff @(negedge rx_backplane_clock or posedge rst) begin
    if (rst) begin
      ser_neg_q <= 1'b0;
      sync_neg_q <= 1'b0;
    end else begin
      ser_neg_q <= ser_q;
      sync_neg_q <= sync_q;
    end
  end

  assign rx_backplane_serial_out = lk_inv ? ser_neg_q : ser_q;
  assign rx_frame_boundary_out = lk_inv ? sync_neg_q : sync_q;
  assign rx_frame_boundary_oe = lk_sync_out;

  // gray frame count crosses back to the bus side
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frame_cnt_s1_q <= 8'h00;
      frame_cnt_s2_q <= 8'h00;
      lb_sys_s1_q <= 4'h0;
    end else begin
      frame_cnt_s1_q <= frame_gray_q;
      frame_cnt_s2_q <= frame_cnt_s1_q;
      lb_sys_s1_q <= line_bits;
    end
  end
  always_comb begin
    frame_cnt_sys[7] = frame_cnt_s2_q[7];
    for (int i = 6; i >= 0; i--) begin
      frame_cnt_sys[i] = frame_cnt_sys[i + 1] ^ frame_cnt_s2_q[i];
    end
  end

  // checks
  a_inv_base_only: assert property (@(posedge rx_backplane_clock)
    disable iff (rst) (lk_mux || lk_mode != rx_bp_pkg::mode_base)
    |-> (rx_backplane_serial_out == ser_q))
    else $error("edge invert active outside base rate");
  a_mux_lane_step: assert property (@(posedge rx_backplane_clock)
    disable iff (rst || rst_l2_q) (lk_mux && $stable(lk_mux) && !fb_s2_q)
    |=> (lane_q == $past(lane_q) + 2'h1))
    else $error("interleave lane did not advance");
  a_sync_hs_input: assert property (@(posedge rx_backplane_clock)
    disable iff (rst) (lk_mode != rx_bp_pkg::mode_base || lk_mux)
    |-> !rx_frame_boundary_oe)
    else $error("frame boundary driven in high-speed mode");
  a_bus_write_resp: assert property (@(posedge clk_sys) disable iff (rst)
    (aw_have_q && w_have_q && !bvalid_q) |=> bvalid_q)
    else $error("write response missing");
  a_base_bit_path: assert property (@(posedge rx_backplane_clock)
    disable iff (rst) !lk_mux |=> (ser_q == $past(lb_s2_q[0])))
    else $error("base rate data bit not taken from channel zero");
  a_frame_pulse_one: assert property (@(posedge rx_backplane_clock)
    disable iff (rst) sync_q |=> !sync_q)
    else $error("frame boundary pulse longer than one bit time");
endmodule : rx_bp_config

`default_nettype wire
